// ---- design/ddr_cell_port_defs.vh ----
// constants shared by the double-rate cell port and its helpers
// assumes inclusion by bare name from design files only
`ifndef DDR_CELL_PORT_DEFS_VH
`define DDR_CELL_PORT_DEFS_VH

// link and internal widths
`define OCTET_W 8
`define WORD_W 32
`define OCTETS_PER_WORD 4
`define SLOT_W 2

// programmable minimum cell size, in octets (4..124, step 4)
`define MIN_CELL_W 7
`define MIN_CELL_LSB 2
`define CELL_WORDS_W 5
`define CELL_WORDS_MAX 5'h1F

// octet lane positions inside a word, first octet highest
`define OCTET0_MSB 31
`define OCTET1_MSB 23

// transmit fifo
`define TX_FIFO_DEPTH 16
`define TX_FIFO_AW 4

// transmit slot timing: system cycles per half octet slot
`define TX_HALF_SLOT_CYCLES 2
`define TX_HALF_CNT_W 2

// pin synchroniser depth
`define SYNC_STAGES 3

// idle fill sent when no word waits
`define TX_IDLE_WORD 32'h0000_0000

`endif

// ---- design/pin_sync.v ----
// three flip-flop synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to i_clk; output is a stable registered level
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire [WIDTH-1:0] i_async,
   output reg [WIDTH-1:0] o_stable
);
   reg [WIDTH-1:0] s1_reg;
   reg [WIDTH-1:0] s2_reg;
   reg [WIDTH-1:0] s3_reg;
   integer k;

   // first stage feeds only the second; per bit, a change counts once stages two and three agree
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         s1_reg <= {WIDTH{1'b0}};
         s2_reg <= {WIDTH{1'b0}};
         s3_reg <= {WIDTH{1'b0}};
         o_stable <= {WIDTH{1'b0}};
      end else begin
         s1_reg <= i_async;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (k = 0; k < WIDTH; k = k + 1) begin
            if (s2_reg[k] == s3_reg[k]) begin
               o_stable[k] <= s3_reg[k];
            end
         end
      end
   end
endmodule

// ---- design/cell_fifo.v ----
// word fifo with registered output stage, valid and ready on both sides
// assumes single clock; in_ready and out_valid come from flip-flops
`timescale 1ns/100ps
module cell_fifo #(
   parameter WIDTH = 33,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_in_valid,
   input wire [WIDTH-1:0] i_in_data,
   output reg o_in_ready,
   output reg o_out_valid,
   output reg [WIDTH-1:0] o_out_data,
   input wire i_out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] cnt_reg;
   reg [AW:0] cnt_next;
   wire push;
   wire load;

   assign push = i_in_valid & o_in_ready;
   assign load = (~o_out_valid | i_out_ready) & (cnt_reg != {(AW+1){1'b0}});

   always @* begin
      cnt_next = cnt_reg;
      if (push & ~load) begin
         cnt_next = cnt_reg + {{AW{1'b0}}, 1'b1};
      end else if (load & ~push) begin
         cnt_next = cnt_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   always @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end

   // ready drops once storage is full, so back-pressure reaches the writer
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
         o_out_data <= {WIDTH{1'b0}};
      end else begin
         cnt_reg <= cnt_next;
         o_in_ready <= (cnt_next < DEPTH);
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (load) begin
            o_out_data <= mem[rd_ptr_reg];
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
            o_out_valid <= 1'b1;
         end else if (i_out_ready) begin
            o_out_valid <= 1'b0;
         end
      end
   end
endmodule

// ---- design/ddr_cell_port_gearbox.v ----
// byte-wide double-rate cell port: link octets to 32-bit words and back
// assumes link pins asynchronous to i_clk; fabric side on i_clk
// Function
// RULE_01: three ports exist; port zero always usable, others only when serial channels idle
// RULE_02: byte-wide double-edge link maps onto a single-edge 32-bit internal bus
// RULE_03: internal word rate is half the link clock rate
// RULE_04: octets of a cell follow without gaps; next start ends previous cell
// RULE_05: start-of-cell accompanies cell, first octet on forwarded clock rising edge
// RULE_06: receiver captures octets on both clock edges, gathers four per word
// RULE_07: far end forwards receive clock 120 to 311 MHz centred in data eye
// RULE_08: sender spaces starts by two-clock multiples, only in rising-edge slots
// RULE_09: first octet lands on bits 31:24, second on 23:16, then lower
// RULE_10: sender makes every cell a whole number of four-octet words
// RULE_11: minimum cell size programmable four to 124 octets in steps of four
// RULE_12: cell shorter than programmed minimum raises the short-cell flag
// RULE_13: transmitter splits each word into four octets on both clock edges
// RULE_14: transmit start marks octet 0; its transitions sit 90 degrees off clock
// RULE_15: forwarded transmit clock is shifted 90 degrees from data transitions
// RULE_16: outputs launch from the fast clock, even and odd octets alternate
// RULE_17: fast transmit clock is four times base rate, 240 to 284 MHz
// RULE_18: alignment error pulses one word cycle with start when caught on falling edge
// RULE_19: short-cell output rises with the start of the overrunning cell
// RULE_20: fabric raises cell processing enable after reset with stable controls
// RULE_21: drive disable low tristates transmit data, start and clock drivers
`timescale 1ns/100ps
`include "ddr_cell_port_defs.vh"
module ddr_cell_port_gearbox #(
   parameter PORT_INDEX = 0
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_serial_channels_busy,
   input wire i_cell_proc_enable,
   input wire [`MIN_CELL_W-1:0] i_min_cell_octets,
   input wire i_rx_fwd_clock,
   input wire i_rx_cell_start,
   input wire [`OCTET_W-1:0] i_rx_data,
   output reg o_rx_word_clock,
   output reg o_rx_valid,
   output reg [`WORD_W-1:0] o_rx_data,
   output reg o_rx_cell_start,
   output reg o_short_cell_out,
   output reg o_cell_align_error,
   input wire i_tx_valid,
   input wire [`WORD_W-1:0] i_tx_data,
   input wire i_tx_cell_start,
   output wire o_tx_ready,
   input wire i_tx_drive_disable_n,
   output reg [`OCTET_W-1:0] o_tx_data,
   output reg o_tx_cell_start,
   output reg o_tx_fwd_clock,
   output reg o_tx_oe,
   output reg o_port_available
);
   // place one octet in its lane of a word; lane 0 is the most significant byte
   function [`WORD_W-1:0] put_octet;
      input [`WORD_W-1:0] word;
      input [`SLOT_W-1:0] slot;
      input [`OCTET_W-1:0] octet;
      begin
         put_octet = word;
         case (slot)
            2'd0: put_octet[`OCTET0_MSB -: `OCTET_W] = octet;
            2'd1: put_octet[`OCTET1_MSB -: `OCTET_W] = octet;
            2'd2: put_octet[15:8] = octet;
            default: put_octet[7:0] = octet;
         endcase
      end
   endfunction

   // pick one octet of a word by lane, same order as above
   function [`OCTET_W-1:0] get_octet;
      input [`WORD_W-1:0] word;
      input [`SLOT_W-1:0] slot;
      begin
         case (slot)
            2'd0: get_octet = word[`OCTET0_MSB -: `OCTET_W];
            2'd1: get_octet = word[`OCTET1_MSB -: `OCTET_W];
            2'd2: get_octet = word[15:8];
            default: get_octet = word[7:0];
         endcase
      end
   endfunction

   // port usability and enable
   reg port_on_reg;
   // RULE_01 port availability gate
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_port_available <= 1'b0;
         port_on_reg <= 1'b0;
      end else begin
         o_port_available <= (PORT_INDEX == 0) | ~i_serial_channels_busy;
         // RULE_20 wait for fabric enable
         port_on_reg <= ((PORT_INDEX == 0) | ~i_serial_channels_busy) & i_cell_proc_enable;
      end
   end

   // receive side: all link pins go through the same synchroniser so data stays aligned with the clock
   wire [`OCTET_W+1:0] rx_pins_s;
   wire rx_clk_s;
   wire rx_soc_s;
   wire [`OCTET_W-1:0] rx_data_s;
   reg rx_clk_prev_reg;
   wire rx_rise;
   wire rx_fall;

   pin_sync #(
      .WIDTH(`OCTET_W+2)
   ) u_rx_sync (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_async({i_rx_fwd_clock, i_rx_cell_start, i_rx_data}),
      .o_stable(rx_pins_s)
   );

   assign rx_clk_s = rx_pins_s[`OCTET_W+1];
   assign rx_soc_s = rx_pins_s[`OCTET_W];
   assign rx_data_s = rx_pins_s[`OCTET_W-1:0];
   // RULE_06 both edges give a slot
   assign rx_rise = rx_clk_s & ~rx_clk_prev_reg;
   assign rx_fall = ~rx_clk_s & rx_clk_prev_reg;

   reg [`WORD_W-1:0] rx_word_reg;
   reg [`SLOT_W-1:0] rx_slot_reg;
   reg rx_in_cell_reg;
   reg rx_word_soc_reg;
   reg rx_align_pend_reg;
   reg rx_short_pend_reg;
   reg [`CELL_WORDS_W-1:0] rx_cell_words_reg;
   wire [`CELL_WORDS_W-1:0] min_words;

   // RULE_11 minimum size in whole words
   assign min_words = i_min_cell_octets[`MIN_CELL_W-1:`MIN_CELL_LSB];

   // limitation: link clock must stay well below i_clk/4 for every edge to be seen
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         rx_clk_prev_reg <= 1'b0;
         o_rx_word_clock <= 1'b0;
         rx_word_reg <= {`WORD_W{1'b0}};
         rx_slot_reg <= {`SLOT_W{1'b0}};
         rx_in_cell_reg <= 1'b0;
         rx_word_soc_reg <= 1'b0;
         rx_align_pend_reg <= 1'b0;
         rx_short_pend_reg <= 1'b0;
         rx_cell_words_reg <= {`CELL_WORDS_W{1'b0}};
         o_rx_valid <= 1'b0;
         o_rx_data <= {`WORD_W{1'b0}};
         o_rx_cell_start <= 1'b0;
         o_short_cell_out <= 1'b0;
         o_cell_align_error <= 1'b0;
      end else begin
         rx_clk_prev_reg <= rx_clk_s;
         o_rx_valid <= 1'b0;
         o_rx_cell_start <= 1'b0;
         o_short_cell_out <= 1'b0;
         o_cell_align_error <= 1'b0;
         // RULE_03 word clock at half link rate
         if (rx_rise) begin
            o_rx_word_clock <= ~o_rx_word_clock;
         end
         if (!port_on_reg) begin
            rx_in_cell_reg <= 1'b0;
            rx_slot_reg <= {`SLOT_W{1'b0}};
         end else if (rx_rise | rx_fall) begin
            if (rx_soc_s) begin
               // RULE_04 new start closes previous cell
               // RULE_09 first octet into top lane
               rx_word_reg <= put_octet({`WORD_W{1'b0}}, 2'd0, rx_data_s);
               rx_slot_reg <= 2'd1;
               rx_in_cell_reg <= 1'b1;
               rx_word_soc_reg <= 1'b1;
               // RULE_18 start caught on falling edge
               rx_align_pend_reg <= rx_fall;
               // RULE_12 short previous cell check
               rx_short_pend_reg <= rx_in_cell_reg & (rx_cell_words_reg < min_words);
               rx_cell_words_reg <= {`CELL_WORDS_W{1'b0}};
            end else if (rx_in_cell_reg) begin
               // RULE_06 gather four octets
               if (rx_slot_reg == 2'd3) begin
                  // RULE_02 word on one edge
                  o_rx_data <= put_octet(rx_word_reg, rx_slot_reg, rx_data_s);
                  o_rx_valid <= 1'b1;
                  o_rx_cell_start <= rx_word_soc_reg;
                  // RULE_19 flag with new cell start
                  o_short_cell_out <= rx_word_soc_reg & rx_short_pend_reg;
                  // RULE_18 one word cycle pulse
                  o_cell_align_error <= rx_word_soc_reg & rx_align_pend_reg;
                  rx_word_soc_reg <= 1'b0;
                  rx_align_pend_reg <= 1'b0;
                  rx_short_pend_reg <= 1'b0;
                  if (rx_cell_words_reg != `CELL_WORDS_MAX) begin
                     rx_cell_words_reg <= rx_cell_words_reg + 5'd1;
                  end
               end else begin
                  rx_word_reg <= put_octet(rx_word_reg, rx_slot_reg, rx_data_s);
               end
               rx_slot_reg <= rx_slot_reg + 2'd1;
            end
         end
      end
   end

   // transmit side: fabric words wait in the fifo, the slot engine drains it
   wire tx_fifo_valid;
   wire [`WORD_W:0] tx_fifo_data;
   reg tx_pop;

   cell_fifo #(
      .WIDTH(`WORD_W+1),
      .DEPTH(`TX_FIFO_DEPTH),
      .AW(`TX_FIFO_AW)
   ) u_tx_fifo (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_in_valid(i_tx_valid),
      .i_in_data({i_tx_cell_start, i_tx_data}),
      .o_in_ready(o_tx_ready),
      .o_out_valid(tx_fifo_valid),
      .o_out_data(tx_fifo_data),
      .i_out_ready(tx_pop)
   );

   reg [`TX_HALF_CNT_W-1:0] tx_half_cnt_reg;
   reg tx_half_tick_reg;
   reg tx_phase_reg;
   reg [`SLOT_W-1:0] tx_slot_reg;
   reg [`WORD_W-1:0] tx_word_reg;
   wire tx_launch;
   wire [`WORD_W-1:0] tx_cur_word;
   wire tx_cur_soc;

   // RULE_17 fast clock stand-in as an enable divider
   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         tx_half_cnt_reg <= {`TX_HALF_CNT_W{1'b0}};
         tx_half_tick_reg <= 1'b0;
      end else if (tx_half_cnt_reg == `TX_HALF_SLOT_CYCLES - 1) begin
         tx_half_cnt_reg <= {`TX_HALF_CNT_W{1'b0}};
         tx_half_tick_reg <= 1'b1;
      end else begin
         tx_half_cnt_reg <= tx_half_cnt_reg + 2'd1;
         tx_half_tick_reg <= 1'b0;
      end
   end

   assign tx_launch = port_on_reg & tx_half_tick_reg & ~tx_phase_reg;
   // on lane 0 a fresh word is taken straight from the fifo head, or idle fill when it is empty; lanes 1 to 3 read tx_word_reg
   assign tx_cur_word = (tx_slot_reg != 2'd0) ? tx_word_reg :
                        (tx_fifo_valid ? tx_fifo_data[`WORD_W-1:0] : `TX_IDLE_WORD);
   assign tx_cur_soc = (tx_slot_reg == 2'd0) & tx_fifo_valid & tx_fifo_data[`WORD_W];

   always @* begin
      tx_pop = tx_launch & (tx_slot_reg == 2'd0) & tx_fifo_valid;
   end

   always @(posedge i_clk) begin
      if (!i_reset_n) begin
         tx_phase_reg <= 1'b0;
         tx_slot_reg <= {`SLOT_W{1'b0}};
         tx_word_reg <= {`WORD_W{1'b0}};
         o_tx_data <= {`OCTET_W{1'b0}};
         o_tx_cell_start <= 1'b0;
         o_tx_fwd_clock <= 1'b0;
         o_tx_oe <= 1'b0;
      end else begin
         // RULE_21 drivers released while disabled
         o_tx_oe <= i_tx_drive_disable_n;
         if (!port_on_reg) begin
            tx_phase_reg <= 1'b0;
            tx_slot_reg <= {`SLOT_W{1'b0}};
            o_tx_fwd_clock <= 1'b0;
            o_tx_cell_start <= 1'b0;
         end else if (tx_half_tick_reg) begin
            tx_phase_reg <= ~tx_phase_reg;
            if (!tx_phase_reg) begin
               // RULE_13 one octet per slot
               // RULE_16 even and odd lanes alternate
               o_tx_data <= get_octet(tx_cur_word, tx_slot_reg);
               // RULE_14 start marks octet 0 only
               o_tx_cell_start <= tx_cur_soc;
               if (tx_slot_reg == 2'd0) begin
                  tx_word_reg <= tx_cur_word;
                  // later lanes read this copy, the fifo head moves on
               end
               tx_slot_reg <= tx_slot_reg + 2'd1;
            end else begin
               // RULE_15 clock edge mid-slot, quarter period after data
               // RULE_05 lane 0 sits under a rising edge
               o_tx_fwd_clock <= ~o_tx_fwd_clock;
            end
         end
      end
   end
endmodule

// ---- test/ddr_cell_port_gearbox_checker.sv ----
// concurrent checks on the double-rate cell port, bound to its top module
// assumes registered outputs and two i_clk per transmit half slot
`timescale 1ns/100ps
module ddr_cell_port_gearbox_checker #(
   parameter PORT_INDEX = 0
) (
   input wire i_clk,
   input wire i_reset_n,
   input wire i_serial_channels_busy,
   input wire i_tx_drive_disable_n,
   input wire o_rx_valid,
   input wire [31:0] o_rx_data,
   input wire o_rx_cell_start,
   input wire o_short_cell_out,
   input wire o_cell_align_error,
   input wire [7:0] o_tx_data,
   input wire o_tx_cell_start,
   input wire o_tx_fwd_clock,
   input wire o_tx_oe,
   input wire o_tx_ready,
   input wire o_port_available
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // first edge after release still shows reset values, hence the past guard
   a_port_avail: assert property ($past(i_reset_n) |->
      o_port_available == (PORT_INDEX == 0 || !$past(i_serial_channels_busy))) else $error("port availability wrong");
   a_rx_hold: assert property (!o_rx_valid |-> $stable(o_rx_data)) else $error("rx word moved without valid");
   a_word_rate: assert property (o_rx_valid |=> !o_rx_valid [*8]) else $error("rx words too close");
   a_start_valid: assert property (o_rx_cell_start |-> o_rx_valid) else $error("cell start without word");
   a_short_start: assert property (o_short_cell_out |-> o_rx_valid && o_rx_cell_start)
      else $error("short flag off its start");
   a_align_start: assert property (o_cell_align_error |-> o_rx_cell_start && o_rx_valid)
      else $error("align flag off its start");
   a_octet_stands: assert property ($changed(o_tx_data) |=> $stable(o_tx_data) [*3])
      else $error("tx octet too short");
   a_clock_quadrature: assert property ($changed(o_tx_fwd_clock) |-> $stable(o_tx_data) && $stable(o_tx_cell_start))
      else $error("tx clock moved with data");
   a_fast_clock_ratio: assert property ($rose(o_tx_fwd_clock) |=> $stable(o_tx_fwd_clock) [*3] ##1 $fell(o_tx_fwd_clock))
      else $error("tx clock half period wrong");
   a_start_lane0: assert property ($rose(o_tx_cell_start) |-> ##2 $rose(o_tx_fwd_clock) ##2 $fell(o_tx_cell_start))
      else $error("tx start not on octet 0");
   a_drive_off: assert property (!i_tx_drive_disable_n [*2] |-> !o_tx_oe) else $error("tx drivers not released");
   c_short: cover property (o_short_cell_out);
   c_align: cover property (o_cell_align_error);
   c_full: cover property ($fell(o_tx_ready));
endmodule

bind ddr_cell_port_gearbox ddr_cell_port_gearbox_checker #(.PORT_INDEX(PORT_INDEX)) checker_i (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_serial_channels_busy(i_serial_channels_busy),
   .i_tx_drive_disable_n(i_tx_drive_disable_n), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
   .o_rx_cell_start(o_rx_cell_start), .o_short_cell_out(o_short_cell_out), .o_cell_align_error(o_cell_align_error),
   .o_tx_data(o_tx_data), .o_tx_cell_start(o_tx_cell_start), .o_tx_fwd_clock(o_tx_fwd_clock),
   .o_tx_oe(o_tx_oe), .o_tx_ready(o_tx_ready), .o_port_available(o_port_available));

// ---- test/link_partner.sv ----
// behavioural cell scheduler on the far side of the link
// assumes a 200 ns link clock that stands at 0 between frames
`timescale 1ns/100ps
module link_partner (
   output logic o_link_clk,
   output logic o_link_start,
   output logic [7:0] o_link_data,
   input wire i_tx_clk,
   input wire i_tx_start,
   input wire [7:0] i_tx_data,
   input wire i_tx_oe
);
   logic [8:0] tx_q[$];
   initial begin
      o_link_clk = 1'b0;
      o_link_start = 1'b0;
      o_link_data = 8'h00;
   end
   // gapless whole words, start on rising slot
   // skew puts the start on a falling slot, only when a scenario asks for it
   task automatic send_cell(input logic [7:0] base, input int words, input bit skew);
      for (int i = 0; i < words * 4 + (skew ? 2 : 0); i++) begin
         o_link_data = skew ? base + 8'(i - 1) : base + 8'(i);
         o_link_start = (i == (skew ? 1 : 0));
         #50;
         o_link_clk = ~o_link_clk;
         #50;
      end
      o_link_start = 1'b0;
      // released lines carry no stale value
      o_link_data = ~o_link_data;
   endtask
   // capture on both forwarded clock edges
   always @(i_tx_clk) begin
      if (i_tx_oe === 1'b1) begin
         tx_q.push_back({i_tx_start, i_tx_data});
      end
   end
endmodule

// ---- test/ddr_cell_port_gearbox_test.sv ----
// self-checking bench for the double-rate cell port
// assumes link_partner on the link side and the bound checker
`timescale 1ns/100ps
module ddr_cell_port_gearbox_test;
   logic i_clk, i_reset_n, i_serial_channels_busy, i_cell_proc_enable, i_tx_valid, i_tx_cell_start;
   logic i_tx_drive_disable_n, o_rx_word_clock, o_rx_valid, o_rx_cell_start, o_short_cell_out;
   logic o_cell_align_error, o_tx_ready, o_tx_cell_start, o_tx_fwd_clock, o_tx_oe, o_port_available;
   logic [6:0] i_min_cell_octets;
   logic [7:0] o_tx_data;
   logic [31:0] o_rx_data, i_tx_data;
   wire link_clk, link_start;
   wire [7:0] link_data;
   logic [34:0] rx_q[$];
   int fail_count, comparisons, cycles, waits, wclk_edges;

   ddr_cell_port_gearbox #(.PORT_INDEX(1)) ddr_cell_port_gearbox_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_serial_channels_busy(i_serial_channels_busy), .i_cell_proc_enable(i_cell_proc_enable),
      .i_min_cell_octets(i_min_cell_octets), .i_rx_fwd_clock(link_clk), .i_rx_cell_start(link_start),
      .i_rx_data(link_data), .o_rx_word_clock(o_rx_word_clock), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
      .o_rx_cell_start(o_rx_cell_start), .o_short_cell_out(o_short_cell_out),
      .o_cell_align_error(o_cell_align_error), .i_tx_valid(i_tx_valid), .i_tx_data(i_tx_data),
      .i_tx_cell_start(i_tx_cell_start), .o_tx_ready(o_tx_ready), .i_tx_drive_disable_n(i_tx_drive_disable_n),
      .o_tx_data(o_tx_data), .o_tx_cell_start(o_tx_cell_start), .o_tx_fwd_clock(o_tx_fwd_clock),
      .o_tx_oe(o_tx_oe), .o_port_available(o_port_available));
   link_partner link_partner_i (.o_link_clk(link_clk), .o_link_start(link_start), .o_link_data(link_data),
      .i_tx_clk(o_tx_fwd_clock), .i_tx_start(o_tx_cell_start), .i_tx_data(o_tx_data), .i_tx_oe(o_tx_oe));

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // flags stand one cycle, so the falling edge sees each word once
   always @(negedge i_clk) begin
      if (o_rx_valid === 1'b1) begin
         rx_q.push_back({o_cell_align_error, o_short_cell_out, o_rx_cell_start, o_rx_data});
      end
   end
   // word clock toggles once per synced rising link edge
   always @(o_rx_word_clock) begin
      wclk_edges++;
   end
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("[FAIL] %0t run did not finish", $time);
         finish_test();
      end
   end

   task finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task check_word(input logic [34:0] got, input logic [34:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task check_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] oct4(input logic [7:0] b);
      return {b, b + 8'h01, b + 8'h02, b + 8'h03};
   endfunction
   // sends one cell and compares every word with its flags
   task automatic rx_cell(input logic [7:0] base, input int words, input bit skew, input logic shrt);
      logic [34:0] got;
      wclk_edges = 0;
      link_partner_i.send_cell(base, words, skew);
      repeat (12) @(negedge i_clk);
      check_word(35'(wclk_edges), 35'(2 * words + (skew ? 1 : 0)));
      check_word(35'(rx_q.size()), 35'(words));
      for (int j = 0; j < words && rx_q.size() > 0; j++) begin
         got = rx_q.pop_front();
         check_word(got, {j == 0 && skew, j == 0 && shrt, j == 0, oct4(base + 8'(4 * j))});
      end
   endtask
   // drops valid while refused so a stale word is never taken
   task tx_put(input logic [31:0] d, input logic s);
      @(negedge i_clk);
      if (o_tx_ready !== 1'b1) begin
         i_tx_valid = 1'b0;
         while (o_tx_ready !== 1'b1) begin
            waits++;
            @(negedge i_clk);
         end
      end
      i_tx_valid = 1'b1;
      i_tx_data = d;
      i_tx_cell_start = s;
   endtask

   task t_port_gate();
      check_flag(o_port_available, 1'b0);
      link_partner_i.send_cell(8'h50, 1, 0);
      repeat (12) @(negedge i_clk);
      check_word(35'(rx_q.size()), 35'h0_0000_0000);
      i_serial_channels_busy = 1'b0;
      repeat (3) @(negedge i_clk);
      check_flag(o_port_available, 1'b1);
   endtask
   task t_short_cells();
      i_min_cell_octets = 7'h0C;
      rx_cell(8'h20, 2, 0, 1'b1);
      rx_cell(8'h40, 3, 0, 1'b1);
      rx_cell(8'h60, 1, 0, 1'b0);
      i_min_cell_octets = 7'h7C;
      rx_cell(8'h70, 1, 0, 1'b1);
   endtask
   task t_tx_burst();
      int s;
      s = -1;
      link_partner_i.tx_q.delete();
      waits = 0;
      for (int i = 0; i < 20; i++) begin
         tx_put(i * 32'h0101_0101 + 32'h0010_2030, i == 0);
      end
      @(negedge i_clk);
      i_tx_valid = 1'b0;
      check_flag(waits > 0, 1'b1);
      repeat (400) @(negedge i_clk);
      check_flag(o_tx_ready, 1'b1);
      foreach (link_partner_i.tx_q[k]) begin
         if (s < 0 && link_partner_i.tx_q[k][8] === 1'b1) begin
            s = k;
         end
      end
      check_flag(s >= 0 && s + 80 <= link_partner_i.tx_q.size(), 1'b1);
      for (int n = 0; n < 80 && s >= 0 && s + n < link_partner_i.tx_q.size(); n++) begin
         check_word(35'(link_partner_i.tx_q[s + n]), 35'({n == 0, 8'(n / 4 + 16 * (n % 4))}));
      end
   endtask
   task t_drive_off();
      i_tx_drive_disable_n = 1'b0;
      repeat (3) @(negedge i_clk);
      check_flag(o_tx_oe, 1'b0);
      i_tx_drive_disable_n = 1'b1;
      repeat (3) @(negedge i_clk);
      check_flag(o_tx_oe, 1'b1);
   endtask

   initial begin
      i_reset_n = 1'b0;
      i_serial_channels_busy = 1'b1;
      i_cell_proc_enable = 1'b0;
      i_min_cell_octets = 7'h04;
      i_tx_valid = 1'b0;
      i_tx_data = 32'h0000_0000;
      i_tx_cell_start = 1'b0;
      i_tx_drive_disable_n = 1'b1;
      repeat (3) @(negedge i_clk);
      i_reset_n = 1'b1;
      @(negedge i_clk);
      i_cell_proc_enable = 1'b1;
      repeat (4) @(negedge i_clk);
      t_port_gate();
      rx_cell(8'h10, 2, 0, 1'b0);
      t_short_cells();
      i_min_cell_octets = 7'h04;
      rx_cell(8'h80, 1, 1, 1'b0);
      t_tx_burst();
      t_drive_off();
      finish_test();
   end
endmodule
